// ### rtl/dtc_top.sv
`timescale 1ns/1ns
`include "dtc_cfg.svh"

module dtc_top
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  // Avalon-MM register slave
  input  wire logic [9:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic      [31:0]  avs_readdata,
  output logic              avs_waitrequest,
  // Count pins, toggle outputs on the same pins
  input  wire logic [1:0]   count_pin_in,
  output logic      [1:0]   count_pin_out,
  output logic      [1:0]   count_pin_oe_n,
  // External interrupt pins used for gating
  input  wire logic [1:0]   ext_irq_pin,
  // Interrupt service entry, one pulse per unit
  input  wire logic [1:0]   irq_service_ack,
  // Interrupt
  output logic              irq
);
  import dtc_pkg::*;

  // ****************************************************************************
  // Counting step
  // ****************************************************************************

  // Returns the overflow bit, the new high byte and the new low byte.
  function automatic logic [16:0] dtc_step
  (
    input dtc_mode_t   md,
    input logic [7:0]  hi,
    input logic [7:0]  lo
  );
    logic [12:0] v13;
    logic [15:0] v16;
    logic [7:0]  v8;
    v13 = {hi, lo[4:0]} + 13'h0001;
    v16 = {hi, lo} + 16'h0001;
    v8  = lo + 8'h01;
    case (md)
      DTC_MODE_13BIT:
      begin
        // The upper three low-byte bits sit outside the count and never change.
        dtc_step = {({hi, lo[4:0]} == 13'h1FFF), v13[12:5], lo[7:5], v13[4:0]};
      end
      DTC_MODE_16BIT:
      begin
        dtc_step = {({hi, lo} == 16'hFFFF), v16};
      end
      DTC_MODE_RELOAD:
      begin
        if (lo == 8'hFF)
        begin
          dtc_step = {1'b1, hi, hi};
        end
        else
        begin
          dtc_step = {1'b0, hi, v8};
        end
      end
      default:
      begin
        dtc_step = {(lo == 8'hFF), hi, v8};
      end
    endcase
  endfunction

  // ****************************************************************************
  // State
  // ****************************************************************************

  dtc_state_t st_ff;
  dtc_state_t nxt_st;

  logic              presc_tick;
  logic [1:0]        timer_tick;
  logic [1:0]        pin_fall;
  logic [1:0]        src_tick;
  logic [1:0]        gate_ok;
  logic [1:0]        unit_inc;
  logic [1:0][16:0]  step;
  logic [1:0]        ovf;
  logic [7:0]        idx;
  logic [7:0]        wbyte;
  logic              wr_go;
  logic [7:0]        rd_byte;
  logic [1:0]        flag_sw;
  logic [1:0]        flag_clr;

  assign presc_tick = (st_ff.presc == `DTC_PRESC_LAST);
  assign idx        = avs_address[9:2];
  assign wbyte      = avs_writedata[7:0];

  // ****************************************************************************
  // Per-unit tick sources
  // ****************************************************************************

  genvar u;
  generate
    for (u = 0; u < 2; u = u + 1)
    begin : g_unit
      assign timer_tick[u] = st_ff.fast[u] | presc_tick;
      // Only the second and third sync stages are compared here.
      assign pin_fall[u]   = st_ff.pin_sync[u][2] & ~st_ff.pin_sync[u][1];
      assign src_tick[u]   = st_ff.mode_cfg[u * `DTC_MD_UNIT_STRIDE + `DTC_MD_FUNC_SEL] ?
                             pin_fall[u] : timer_tick[u];
      assign gate_ok[u]    = st_ff.run[u] &
                             (~st_ff.mode_cfg[u * `DTC_MD_UNIT_STRIDE + `DTC_MD_GATE] |
                              st_ff.irq_sync[u][1]);
      assign unit_inc[u]   = src_tick[u] & gate_ok[u];
      assign step[u]       = dtc_step(dtc_mode_t'(st_ff.mode_cfg[u * `DTC_MD_UNIT_STRIDE +: 2]),
                                      st_ff.cnt_hi[u], st_ff.cnt_lo[u]);
    end
  endgenerate

  // ****************************************************************************
  // Read decode
  // ****************************************************************************

  always_comb
  begin
    case (idx)
      `DTC_IDX_RUN_FLAG: rd_byte = {st_ff.flag[1], st_ff.run[1], st_ff.flag[0], st_ff.run[0], 4'h0};
      `DTC_IDX_MODE:     rd_byte = st_ff.mode_cfg;
      `DTC_IDX_U0_LOW:   rd_byte = st_ff.cnt_lo[0];
      `DTC_IDX_U1_LOW:   rd_byte = st_ff.cnt_lo[1];
      `DTC_IDX_U0_HIGH:  rd_byte = st_ff.cnt_hi[0];
      `DTC_IDX_U1_HIGH:  rd_byte = st_ff.cnt_hi[1];
      `DTC_IDX_CLK_CFG:  rd_byte = {3'h0, st_ff.fast, 3'h0};
      `DTC_IDX_PIN_SET:  rd_byte = {4'h0, st_ff.tog_en, 2'h0};
      `DTC_IDX_IRQ_STAT: rd_byte = {6'h00, st_ff.flag};
      `DTC_IDX_IRQ_MASK: rd_byte = {6'h00, st_ff.irq_mask};
      default:           rd_byte = 8'h00;
    endcase
  end

  // ****************************************************************************
  // Next state
  // ****************************************************************************

  always_comb
  begin
    nxt_st   = st_ff;
    ovf      = 2'b00;
    flag_sw  = st_ff.flag;
    flag_clr = 2'b00;

    // Two flip-flops before anything looks at the pins; the third stage feeds edge detection.
    for (int i = 0; i < 2; i++)
    begin
      nxt_st.pin_sync[i] = {st_ff.pin_sync[i][1:0], count_pin_in[i]};
      nxt_st.irq_sync[i] = {st_ff.irq_sync[i][0], ext_irq_pin[i]};
    end

    nxt_st.presc = presc_tick ? 4'h0 : st_ff.presc + 4'h1;

    // Unit 0 counting, either whole or split into two 8-bit halves.
    if (dtc_mode_t'(st_ff.mode_cfg[1:0]) == DTC_MODE_SPLIT)
    begin
      if (unit_inc[0])
      begin
        nxt_st.cnt_lo[0] = step[0][7:0];
        ovf[0]           = step[0][16];
      end
      // The high half borrows unit 1's run bit and flag, so unit 1 should stay halted then.
      if (timer_tick[0] & st_ff.run[1])
      begin
        nxt_st.cnt_hi[0] = st_ff.cnt_hi[0] + 8'h01;
        ovf[1]           = (st_ff.cnt_hi[0] == 8'hFF);
      end
    end
    else if (unit_inc[0])
    begin
      nxt_st.cnt_hi[0] = step[0][15:8];
      nxt_st.cnt_lo[0] = step[0][7:0];
      ovf[0]           = step[0][16];
    end

    // Unit 1 counting; the split code halts it.
    if (unit_inc[1] && (dtc_mode_t'(st_ff.mode_cfg[5:4]) != DTC_MODE_SPLIT))
    begin
      nxt_st.cnt_hi[1] = step[1][15:8];
      nxt_st.cnt_lo[1] = step[1][7:0];
      ovf[1]           = ovf[1] | step[1][16];
    end

    // Register slave: one wait cycle, then the access completes.
    wr_go = 1'b0;
    if ((avs_read | avs_write) & st_ff.wait_req)
    begin
      nxt_st.wait_req = 1'b0;
      nxt_st.rdata    = avs_read ? {24'h000000, rd_byte} : 32'h00000000;
    end
    else
    begin
      nxt_st.wait_req = 1'b1;
      wr_go           = avs_write & ~st_ff.wait_req & avs_byteenable[0];
    end

    if (wr_go)
    begin
      case (idx)
        `DTC_IDX_RUN_FLAG:
        begin
          nxt_st.run = {wbyte[`DTC_RF_U1_RUN], wbyte[`DTC_RF_U0_RUN]};
          flag_sw    = {wbyte[`DTC_RF_U1_FLAG], wbyte[`DTC_RF_U0_FLAG]};
        end
        `DTC_IDX_MODE:     nxt_st.mode_cfg  = wbyte;
        `DTC_IDX_U0_LOW:   nxt_st.cnt_lo[0] = wbyte;
        `DTC_IDX_U1_LOW:   nxt_st.cnt_lo[1] = wbyte;
        `DTC_IDX_U0_HIGH:  nxt_st.cnt_hi[0] = wbyte;
        `DTC_IDX_U1_HIGH:  nxt_st.cnt_hi[1] = wbyte;
        `DTC_IDX_CLK_CFG:  nxt_st.fast      = wbyte[`DTC_CK_U0_FAST +: 2];
        `DTC_IDX_PIN_SET:  nxt_st.tog_en    = wbyte[`DTC_PS_U0_TOG_EN +: 2];
        `DTC_IDX_IRQ_STAT: flag_clr         = wbyte[1:0];
        `DTC_IDX_IRQ_MASK: nxt_st.irq_mask  = wbyte[1:0];
        default:
        begin
        end
      endcase
    end

    // An overflow in the same cycle as any clear still leaves the flag set.
    nxt_st.flag = (flag_sw & ~flag_clr & ~irq_service_ack) | ovf;

    for (int i = 0; i < 2; i++)
    begin
      if (!nxt_st.tog_en[i])
      begin
        nxt_st.tog[i] = 1'b1;
      end
      else if (ovf[i])
      begin
        nxt_st.tog[i] = ~st_ff.tog[i];
      end
    end
    nxt_st.pin_oe_n = ~nxt_st.tog_en;

    nxt_st.irq = |(nxt_st.flag & nxt_st.irq_mask);
  end

  // ****************************************************************************
  // Registers
  // ****************************************************************************

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      st_ff          <= '0;
      st_ff.mode_cfg <= `DTC_RST_BYTE;
      st_ff.irq_mask <= `DTC_RST_MASK;
      st_ff.tog      <= 2'h3;
      st_ff.pin_oe_n <= 2'h3;
      st_ff.wait_req <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign avs_readdata    = st_ff.rdata;
  assign avs_waitrequest = st_ff.wait_req;
  assign count_pin_out   = st_ff.tog;
  assign count_pin_oe_n  = st_ff.pin_oe_n;
  assign irq             = st_ff.irq;

endmodule

// ### rtl/dtc_cfg.svh
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// ****************************************************************************
// Register indexes (byte address is four times the index)
// ****************************************************************************
`define DTC_IDX_RUN_FLAG   8'h88
`define DTC_IDX_MODE       8'h89
`define DTC_IDX_U0_LOW     8'h8A
`define DTC_IDX_U1_LOW     8'h8B
`define DTC_IDX_U0_HIGH    8'h8C
`define DTC_IDX_U1_HIGH    8'h8D
`define DTC_IDX_CLK_CFG    8'h8E
`define DTC_IDX_PIN_SET    8'hB5
`define DTC_IDX_IRQ_STAT   8'hC0
`define DTC_IDX_IRQ_MASK   8'hC1

// ****************************************************************************
// Field positions
// ****************************************************************************
`define DTC_RF_U0_RUN      4
`define DTC_RF_U0_FLAG     5
`define DTC_RF_U1_RUN      6
`define DTC_RF_U1_FLAG     7
`define DTC_MD_FUNC_SEL    2
`define DTC_MD_GATE        3
`define DTC_MD_UNIT_STRIDE 4
`define DTC_CK_U0_FAST     3
`define DTC_PS_U0_TOG_EN   2

// ****************************************************************************
// Reset values and timing
// ****************************************************************************
`define DTC_RST_BYTE       8'h00
`define DTC_RST_MASK       2'h0
`define DTC_PRESC_DIV      12
`define DTC_PRESC_LAST     4'hB

`endif

// ### rtl/dtc_pkg.sv
package dtc_pkg;

  typedef enum logic [1:0]
  {
    DTC_MODE_13BIT  = 2'b00,
    DTC_MODE_16BIT  = 2'b01,
    DTC_MODE_RELOAD = 2'b10,
    DTC_MODE_SPLIT  = 2'b11
  } dtc_mode_t;

  typedef struct packed
  {
    logic [7:0]       mode_cfg;
    logic [1:0][7:0]  cnt_lo;
    logic [1:0][7:0]  cnt_hi;
    logic [1:0]       run;
    logic [1:0]       flag;
    logic [1:0]       fast;
    logic [1:0]       tog_en;
    logic [1:0]       tog;
    logic [1:0]       pin_oe_n;
    logic [1:0]       irq_mask;
    logic [3:0]       presc;
    logic [1:0][2:0]  pin_sync;
    logic [1:0][1:0]  irq_sync;
    logic             irq;
    logic             wait_req;
    logic [31:0]      rdata;
  } dtc_state_t;

endpackage

// ### dv/dtc_properties.sv
`timescale 1ns/1ns
// ****************
// Port checks
// ****************
module dtc_properties
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_b,
  // Register bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Pins
  input wire logic [1:0]  count_pin_out,
  input wire logic [1:0]  count_pin_oe_n,
  input wire logic [1:0]  irq_service_ack,
  input wire logic        irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence acc_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence acc_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  acc_one_a: assert property (acc_req |=> acc_ans)
    else $error("access not answered after one wait cycle");
  wait_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("waitrequest dropped with no request");
  upper_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data above the byte not zero");
  // Reset must win even while the rest are disabled, so it carries its own empty disable.
  reset_pins_a: assert property (disable iff (1'b0) !rst_b |=>
      count_pin_out == 2'h3 && count_pin_oe_n == 2'h3 && !irq)
    else $error("pins or interrupt wrong in reset");
  tog_start_a: assert property ($fell(count_pin_oe_n[0]) |-> count_pin_out[0])
    else $error("toggle output not high when enabled");
  tog_idle_a: assert property (&(count_pin_out | ~(count_pin_oe_n & $past(count_pin_oe_n))))
    else $error("toggle output moved while not driven");
  oe_cause_a: assert property ($changed(count_pin_oe_n) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("drive enable changed without a write");
  ack_clear_a: assert property (irq_service_ack == 2'h3 |=> !irq)
    else $error("interrupt stayed up after service entry");
endmodule

bind dtc_top dtc_properties chk_u (.core_clk, .rst_b, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .count_pin_out, .count_pin_oe_n, .irq_service_ack, .irq);

// ### dv/dtc_pins.sv
`timescale 1ns/1ns
// ****************
// Pin side model
// ****************
module dtc_pins
(
  // Clock
  input  wire logic       core_clk,
  // Device side
  input  wire logic [1:0] count_pin_out,
  input  wire logic [1:0] count_pin_oe_n,
  output logic      [1:0] count_pin_in,
  output logic      [1:0] ext_irq_pin
);
  logic [1:0] src  = 2'h3;
  logic [1:0] gate = 2'h3;
  // The device owns the pin while its drive enable is low; the source shows only when released.
  assign count_pin_in = (count_pin_oe_n & src) | (~count_pin_oe_n & count_pin_out);
  assign ext_irq_pin  = gate;
  task gates(input logic [1:0] g);
    @(posedge core_clk);
    gate <= g;
  endtask
  // Each level is held whole cycles so one sample pair sees high then low; hold sets the pace.
  task edges(input int u, input int n, input int hold);
    repeat (n)
    begin
      @(posedge core_clk);
      src[u] <= 1'b0;
      repeat (hold) @(posedge core_clk);
      src[u] <= 1'b1;
      repeat (hold) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
  endtask
endmodule

// ### dv/dual_timer_counter_bench.sv
`timescale 1ns/1ns
module dual_timer_counter_bench;
  typedef struct {logic u; logic [7:0] md, lo, hi; logic [1:0] gt; logic [7:0] elo, ehi; logic eirq;} dtc_row_t;
  typedef struct {logic [7:0] i, w, e;} dtc_reg_t;
  logic        core_clk        = 1'b0;
  logic        rst_b           = 1'b0;
  logic [9:0]  avs_address     = 10'h0;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = 32'h0;
  logic [3:0]  avs_byteenable  = 4'hF;
  logic [1:0]  irq_service_ack = 2'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic [1:0]  count_pin_in, count_pin_out, count_pin_oe_n, ext_irq_pin;
  logic [7:0]  d;
  int          error_cnt = 0;
  int          checks    = 0;
  int          cyc       = 0;
  logic [7:0]  ridx[10] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'hB5, 8'hC0, 8'hC1};
  dtc_reg_t    regs[8] = '{'{8'h89, 8'hA5, 8'hA5}, '{8'h8E, 8'hFF, 8'h18}, '{8'hB5, 8'hFF, 8'h0C},
    '{8'hB5, 8'h00, 8'h00}, '{8'hC1, 8'hFF, 8'h03}, '{8'h3F, 8'hFF, 8'h00}, '{8'h8A, 8'h5A, 8'h5A},
    '{8'h8D, 8'h96, 8'h96}};
  dtc_row_t    rows[9] = '{
    '{0, 8'h05, 8'hFE, 8'hFF, 2'h3, 8'h01, 8'h00, 1},
    '{0, 8'h04, 8'h1E, 8'hFF, 2'h3, 8'h01, 8'h00, 1},
    '{0, 8'h06, 8'hFE, 8'h80, 2'h3, 8'h81, 8'h80, 1},
    '{0, 8'h0D, 8'hFE, 8'hFF, 2'h3, 8'h01, 8'h00, 1},
    '{0, 8'h0D, 8'h10, 8'h00, 2'h2, 8'h10, 8'h00, 0},
    '{1, 8'h50, 8'hFE, 8'hFF, 2'h3, 8'h01, 8'h00, 1},
    '{1, 8'hD0, 8'h10, 8'h00, 2'h1, 8'h10, 8'h00, 0},
    '{1, 8'h70, 8'h10, 8'h00, 2'h3, 8'h10, 8'h00, 0},
    '{0, 8'h07, 8'hFE, 8'h33, 2'h3, 8'h01, 8'h33, 1}};

  dtc_top dut_u (.core_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .count_pin_in, .count_pin_out, .count_pin_oe_n, .ext_irq_pin,
    .irq_service_ack, .irq);
  dtc_pins pins_u (.core_clk, .count_pin_out, .count_pin_oe_n, .count_pin_in, .ext_irq_pin);

  initial forever #2 core_clk = ~core_clk;

  // ****************
  // Bus and check tasks
  // ****************
  task cmp(input logic [31:0] g, e);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] i, v);
    @(posedge core_clk);
    avs_address   <= {i, 2'b00};
    avs_writedata <= {24'h0, v};
    avs_write     <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task rd(input logic [7:0] i, output logic [7:0] v);
    @(posedge core_clk);
    avs_address <= {i, 2'b00};
    avs_read    <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    v = avs_readdata[7:0];
    avs_read <= 1'b0;
  endtask
  task per(input int e);
    logic v;
    int   n;
    v = count_pin_out[0];
    n = 0;
    while (count_pin_out[0] === v && n < 200)
    begin
      @(posedge core_clk);
      n++;
    end
    v = count_pin_out[0];
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (count_pin_out[0] === v && n < 200);
    cmp(n, e);
  endtask
  task run_row(input dtc_row_t r);
    wr(8'h89, r.md);
    wr(8'h8A + r.u, r.lo);
    wr(8'h8C + r.u, r.hi);
    pins_u.gates(r.gt);
    wr(8'h88, r.u ? 8'h40 : 8'h10);
    pins_u.edges(r.u, 3, 2);
    cmp(irq, r.eirq);
    wr(8'h88, 8'h00);
    pins_u.edges(r.u, 2, 1);
    rd(8'h8A + r.u, d);
    cmp(d, r.elo);
    rd(8'h8C + r.u, d);
    cmp(d, r.ehi);
    $display("count row done");
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // A hang anywhere is cut off well past the several hundred cycles the sequence needs.
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      error_cnt++;
      stop_test;
    end
  end

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    foreach (ridx[k])
    begin
      rd(ridx[k], d);
      cmp(d, 8'h00);
    end
    foreach (regs[k])
    begin
      wr(regs[k].i, regs[k].w);
      rd(regs[k].i, d);
      cmp(d, regs[k].e);
    end
    $display("register test done");
    foreach (rows[k]) run_row(rows[k]);
    wr(8'h89, 8'h02);
    wr(8'h8E, 8'h00);
    wr(8'h8C, 8'hFE);
    wr(8'h8A, 8'hFE);
    wr(8'hB5, 8'h04);
    repeat (2) @(posedge core_clk);
    cmp(count_pin_oe_n, 2'h2);
    cmp(count_pin_out, 2'h3);
    wr(8'h88, 8'h10);
    per(24);
    wr(8'h8E, 8'h08);
    per(2);
    cmp(irq, 1'b1);
    wr(8'h88, 8'h20);
    @(posedge core_clk);
    irq_service_ack <= 2'h3;
    @(posedge core_clk);
    irq_service_ack <= 2'h0;
    repeat (2) @(posedge core_clk);
    cmp(irq, 1'b0);
    wr(8'hB5, 8'h00);
    repeat (2) @(posedge core_clk);
    cmp(count_pin_oe_n, 2'h3);
    $display("toggle test done");
    wr(8'h88, 8'hA0);
    rd(8'hC0, d);
    cmp(d, 8'h03);
    cmp(irq, 1'b1);
    wr(8'hC1, 8'h01);
    wr(8'hC0, 8'h01);
    repeat (2) @(posedge core_clk);
    cmp(irq, 1'b0);
    rd(8'hC0, d);
    cmp(d, 8'h02);
    $display("interrupt test done");
    // The high half of a split unit 0 runs on unit 1's run bit and raises unit 1's flag.
    wr(8'h89, 8'h33);
    wr(8'h8E, 8'h08);
    wr(8'h8A, 8'h44);
    wr(8'h8B, 8'h21);
    wr(8'h8C, 8'hFF);
    wr(8'h88, 8'h40);
    repeat (4) @(posedge core_clk);
    rd(8'hC0, d);
    cmp(d, 8'h02);
    cmp(irq, 1'b0);
    wr(8'h88, 8'h00);
    rd(8'h8A, d);
    cmp(d, 8'h44);
    rd(8'h8B, d);
    cmp(d, 8'h21);
    $display("split test done");
    wr(8'hB5, 8'h0C);
    repeat (2) @(posedge core_clk);
    cmp(count_pin_oe_n, 2'h0);
    rst_b <= 1'b0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    cmp(count_pin_oe_n, 2'h3);
    cmp(count_pin_out, 2'h3);
    foreach (ridx[k])
    begin
      rd(ridx[k], d);
      cmp(d, 8'h00);
    end
    // A write without its low byte lane completes on the bus but must leave the register alone.
    avs_byteenable <= 4'hE;
    wr(8'h8B, 8'hFF);
    avs_byteenable <= 4'hF;
    rd(8'h8B, d);
    cmp(d, 8'h00);
    $display("reset test done");
    stop_test;
  end
endmodule
